// ---- dma_channel_event_flags.sv ----
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none

// Contract
// R1: flag register at zero, reset zero, read-only
// R2: bits 31 to 28 read zero
// R3: absent channels read zero, never set
// R4: error event sets bit 4x+3
// R5: half-way event sets bit 4x+2
// R6: completion event sets bit 4x+1
// R7: global bit 4x set while any set
// R8: flags hold until clear register write
// R9: clear register at 4, ones clear
// R10: global clear drops whole channel group
// R11: channel irq when enabled flag set
// R12: simultaneous set and clear leaves set
// R13: group order global, full, half, error
module dma_channel_event_flags
	import dma_flags_pkg::*;
#(
	parameter int NUM_CHANNELS = 7,
	parameter int ADDR_W       = 12
)
(
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [ADDR_W-1:0]       paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	// event strobes from the transfer engine
	input  wire logic [NUM_CHANNELS-1:0] err_evt,
	input  wire logic [NUM_CHANNELS-1:0] half_evt,
	input  wire logic [NUM_CHANNELS-1:0] full_evt,
	// per-channel interrupts
	output logic [NUM_CHANNELS-1:0]      channel_irq
);

	logic [31:0] flag_word;
	logic [31:0] irq_en_word;
	logic [31:0] irq_en_mask;
	logic        clear_wr;
	logic        irq_en_wr;
	logic        flag_wr;
	logic        any_evt;

	// bus slave
	apb_reg_port #(
		.ADDR_W      (ADDR_W)
	) u_port (
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.flag_word   (flag_word),
		.irq_en_word (irq_en_word),
		.clear_wr    (clear_wr),
		.irq_en_wr   (irq_en_wr),
		.flag_wr     (flag_wr)
	);

	// reserved top nibble never holds anything
	assign flag_word[RESERVED_MSB:RESERVED_LSB] = 4'h0; // R2

	// one flag group per channel, absent channels tied to zero
	genvar c;
	generate
		for (c = 0; c < MAX_CHANNELS; c = c + 1)
		begin : g_chan
			localparam int BASE = BITS_PER_CHANNEL * c;
			if (c < NUM_CHANNELS)
			begin : g_live
				logic [3:0] clear_bits;
				logic [3:0] group;

				// only a completed write to the clear register reaches the cells
				assign clear_bits = clear_wr ? pwdata[BASE +: BITS_PER_CHANNEL] : 4'h0; // R9 R10

				event_flag_channel u_cell (
					.pclk        (pclk),
					.presetn     (presetn),
					.err_evt     (err_evt[c]),
					.half_evt    (half_evt[c]),
					.full_evt    (full_evt[c]),
					.clear_bits  (clear_bits),
					.irq_en_bits (irq_en_word[BASE +: BITS_PER_CHANNEL]),
					.flags       (group),
					.irq         (channel_irq[c])
				);

				// group sits at 4x: global, full, half, error upward
				assign flag_word[BASE +: BITS_PER_CHANNEL] = group; // R13
				assign irq_en_mask[BASE +: BITS_PER_CHANNEL] = 4'hE;

				sequence s_err_clear;
					clear_wr && pwdata[field_bit(c, ERROR_POS)] && !err_evt[c];
				endsequence

				sequence s_all_clear;
					clear_wr && pwdata[field_bit(c, GLOBAL_POS)]
						&& !err_evt[c] && !half_evt[c] && !full_evt[c];
				endsequence

				sequence s_no_clear;
					!(clear_wr && (pwdata[field_bit(c, ERROR_POS)]
						|| pwdata[field_bit(c, GLOBAL_POS)]));
				endsequence

				property p_err_set;
					@(posedge pclk) disable iff (!presetn)
					err_evt[c] |=> flag_word[field_bit(c, ERROR_POS)]
						&& flag_word[field_bit(c, GLOBAL_POS)];
				endproperty
				a_err_set: assert property (p_err_set) // R4
					else $error("error event did not set its flag");

				property p_half_set;
					@(posedge pclk) disable iff (!presetn)
					half_evt[c] |=> flag_word[field_bit(c, HALF_POS)];
				endproperty
				a_half_set: assert property (p_half_set) // R5
					else $error("half event did not set its flag");

				property p_full_set;
					@(posedge pclk) disable iff (!presetn)
					full_evt[c] |=> flag_word[field_bit(c, FULL_POS)];
				endproperty
				a_full_set: assert property (p_full_set) // R6
					else $error("full event did not set its flag");

				property p_global;
					@(posedge pclk) disable iff (!presetn)
					|group[ERROR_POS:FULL_POS] |-> group[GLOBAL_POS];
				endproperty
				a_global: assert property (p_global) // R7
					else $error("global flag low while an event flag is set");

				property p_err_hold;
					@(posedge pclk) disable iff (!presetn)
					group[ERROR_POS] ##0 s_no_clear |=> group[ERROR_POS];
				endproperty
				a_err_hold: assert property (p_err_hold) // R8
					else $error("error flag dropped without a clear");

				property p_err_clear;
					@(posedge pclk) disable iff (!presetn)
					s_err_clear |=> !group[ERROR_POS];
				endproperty
				a_err_clear: assert property (p_err_clear) // R9
					else $error("error flag survived its clear");

				property p_all_clear;
					@(posedge pclk) disable iff (!presetn)
					s_all_clear |=> group == 4'h0;
				endproperty
				a_all_clear: assert property (p_all_clear) // R10
					else $error("global clear left a flag set");

				property p_irq;
					@(posedge pclk) disable iff (!presetn)
					##1 channel_irq[c] == |(group[ERROR_POS:FULL_POS]
						& $past(irq_en_word[BASE+ERROR_POS:BASE+FULL_POS]));
				endproperty
				a_irq: assert property (p_irq) // R11
					else $error("channel interrupt disagrees with enabled flags");

				property p_set_wins;
					@(posedge pclk) disable iff (!presetn)
					err_evt[c] && clear_wr && pwdata[field_bit(c, GLOBAL_POS)]
						|=> group[ERROR_POS] && group[GLOBAL_POS];
				endproperty
				a_set_wins: assert property (p_set_wins) // R12
					else $error("event lost to a simultaneous clear");

				// the error flag only ever rises on its own event strobe
				property p_err_only_set;
					@(posedge pclk) disable iff (!presetn)
					!group[ERROR_POS] && !err_evt[c] |=> !group[ERROR_POS];
				endproperty
				a_err_only_set: assert property (p_err_only_set) // R8
					else $error("error flag rose without an event");

				property p_half_hold;
					@(posedge pclk) disable iff (!presetn)
					group[HALF_POS] && !(clear_wr && (pwdata[field_bit(c, HALF_POS)]
						|| pwdata[field_bit(c, GLOBAL_POS)])) |=> group[HALF_POS];
				endproperty
				a_half_hold: assert property (p_half_hold) // R8
					else $error("half flag dropped without a clear");

				property p_full_hold;
					@(posedge pclk) disable iff (!presetn)
					group[FULL_POS] && !(clear_wr && (pwdata[field_bit(c, FULL_POS)]
						|| pwdata[field_bit(c, GLOBAL_POS)])) |=> group[FULL_POS];
				endproperty
				a_full_hold: assert property (p_full_hold) // R8
					else $error("full flag dropped without a clear");

				// global is sticky: only its own clear bit may drop it
				property p_global_hold;
					@(posedge pclk) disable iff (!presetn)
					group[GLOBAL_POS] && !(clear_wr && pwdata[field_bit(c, GLOBAL_POS)])
						|=> group[GLOBAL_POS];
				endproperty
				a_global_hold: assert property (p_global_hold) // R8
					else $error("global flag dropped without its clear");

				property p_half_clear;
					@(posedge pclk) disable iff (!presetn)
					clear_wr && pwdata[field_bit(c, HALF_POS)] && !half_evt[c]
						|=> !group[HALF_POS];
				endproperty
				a_half_clear: assert property (p_half_clear) // R9
					else $error("half flag survived its clear");

				property p_full_clear;
					@(posedge pclk) disable iff (!presetn)
					clear_wr && pwdata[field_bit(c, FULL_POS)] && !full_evt[c]
						|=> !group[FULL_POS];
				endproperty
				a_full_clear: assert property (p_full_clear) // R9
					else $error("full flag survived its clear");
			end
			else
			begin : g_absent
				// absent channel reads zero and has no enables
				assign flag_word[BASE +: BITS_PER_CHANNEL] = 4'h0; // R3
				assign irq_en_mask[BASE +: BITS_PER_CHANNEL] = 4'h0;

				property p_absent_zero;
					@(posedge pclk) disable iff (!presetn)
					flag_word[BASE +: BITS_PER_CHANNEL] == 4'h0
						&& irq_en_word[BASE +: BITS_PER_CHANNEL] == 4'h0;
				endproperty
				a_absent_zero: assert property (p_absent_zero) // R3
					else $error("absent channel shows a flag");
			end
		end
	endgenerate

	assign irq_en_mask[RESERVED_MSB:RESERVED_LSB] = 4'h0;

	// enables are masked so global and absent bits read back zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_en_word <= IRQ_EN_RESET;
		else if (irq_en_wr)
			irq_en_word <= pwdata & irq_en_mask;
	end

	// any event strobe on a live channel
	assign any_evt = (|err_evt) | (|half_evt) | (|full_evt);

	sequence s_flag_write;
		flag_wr && !any_evt;
	endsequence

	property p_flag_ro;
		@(posedge pclk) disable iff (!presetn)
		s_flag_write |=> $stable(flag_word);
	endproperty
	a_flag_ro: assert property (p_flag_ro) // R1
		else $error("write to the flag register changed a flag");

	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && paddr == FLAG_REG_OFS[ADDR_W-1:0]
			|-> prdata[RESERVED_MSB:RESERVED_LSB] == 4'h0;
	endproperty
	a_reserved: assert property (p_reserved) // R2
		else $error("reserved flag bits read nonzero");

	sequence s_setup;
		psel && !penable;
	endsequence

	property p_ready_once;
		@(posedge pclk) disable iff (!presetn)
		s_setup |=> pready ##1 !pready;
	endproperty
	a_ready_once: assert property (p_ready_once)
		else $error("ready not a single access cycle after setup");

	property p_flag_read;
		@(posedge pclk) disable iff (!presetn)
		s_setup ##0 (!pwrite && paddr == FLAG_REG_OFS[ADDR_W-1:0])
			|=> prdata == $past(flag_word) && !pslverr;
	endproperty
	a_flag_read: assert property (p_flag_read) // R1
		else $error("flag read returned wrong data");

	// any address outside the three words answers with an error
	property p_unmapped;
		@(posedge pclk) disable iff (!presetn)
		s_setup ##0 (paddr != FLAG_REG_OFS[ADDR_W-1:0]
			&& paddr != CLEAR_REG_OFS[ADDR_W-1:0]
			&& paddr != IRQ_EN_REG_OFS[ADDR_W-1:0]) |=> pready && pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not flagged as an error");

endmodule // dma_channel_event_flags

`default_nettype wire

// ---- dma_flags_pkg.sv ----
`default_nettype none

package dma_flags_pkg;

	// register offsets within the controller block
	localparam logic [11:0] FLAG_REG_OFS   = 12'h000;
	localparam logic [11:0] CLEAR_REG_OFS  = 12'h004;
	localparam logic [11:0] IRQ_EN_REG_OFS = 12'h008;

	// values after reset
	localparam logic [31:0] FLAG_RESET   = 32'h00000000;
	localparam logic [31:0] IRQ_EN_RESET = 32'h00000000;
	localparam logic [31:0] READ_ZERO    = 32'h00000000;

	// layout of one channel's group of four bits
	localparam int GLOBAL_POS       = 0;
	localparam int FULL_POS         = 1;
	localparam int HALF_POS         = 2;
	localparam int ERROR_POS        = 3;
	localparam int BITS_PER_CHANNEL = 4;
	localparam int MAX_CHANNELS     = 7;
	localparam int RESERVED_LSB     = 28;
	localparam int RESERVED_MSB     = 31;

	// bit index of one field of one channel
	function automatic int field_bit(input int channel, input int pos);
		return BITS_PER_CHANNEL * channel + pos;
	endfunction

endpackage

`default_nettype wire

// ---- event_flag_channel.sv ----
`timescale 1ns/10ps
`default_nettype none

module event_flag_channel
	import dma_flags_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// event strobes from the transfer engine
	input  wire logic       err_evt,
	input  wire logic       half_evt,
	input  wire logic       full_evt,
	// software side
	input  wire logic [3:0] clear_bits,
	input  wire logic [3:0] irq_en_bits,
	// flag group and channel interrupt
	output logic [3:0]      flags,
	output logic            irq
);

	logic [3:0] next_flags;
	logic       clear_all;

	// a set always beats a clear in the same cycle, so no event is lost
	always_comb
	begin
		clear_all = clear_bits[GLOBAL_POS];
		next_flags[ERROR_POS] = err_evt
			| (flags[ERROR_POS] & ~(clear_bits[ERROR_POS] | clear_all)); // R4
		next_flags[HALF_POS] = half_evt
			| (flags[HALF_POS] & ~(clear_bits[HALF_POS] | clear_all)); // R5
		next_flags[FULL_POS] = full_evt
			| (flags[FULL_POS] & ~(clear_bits[FULL_POS] | clear_all)); // R6
		// global stays up while any event flag does, and only its own clear drops it
		next_flags[GLOBAL_POS] = (|next_flags[ERROR_POS:FULL_POS])
			| (flags[GLOBAL_POS] & ~clear_all); // R7
	end

	// flag storage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flags <= FLAG_RESET[3:0];
		else
			flags <= next_flags; // R8 R12
	end

	// channel interrupt is registered from next_flags, so it changes on the same edge as the flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(next_flags[ERROR_POS:FULL_POS] & irq_en_bits[ERROR_POS:FULL_POS]); // R11
	end

endmodule // event_flag_channel

`default_nettype wire

// ---- apb_reg_port.sv ----
`timescale 1ns/10ps
`default_nettype none

module apb_reg_port
	import dma_flags_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// register file side
	input  wire logic [31:0]       flag_word,
	input  wire logic [31:0]       irq_en_word,
	output logic                   clear_wr,
	output logic                   irq_en_wr,
	output logic                   flag_wr
);

	logic        setup;
	logic        access;
	logic        mapped;
	logic [31:0] read_value;

	// read data is captured in the setup cycle, so it shows flags one cycle old
	always_comb
	begin
		setup = psel & ~penable;
		access = psel & penable & pready;
		mapped = 1'b1;
		read_value = READ_ZERO;
		if (paddr == FLAG_REG_OFS[ADDR_W-1:0]) // R1
			read_value = flag_word;
		else if (paddr == CLEAR_REG_OFS[ADDR_W-1:0])
			read_value = READ_ZERO;
		else if (paddr == IRQ_EN_REG_OFS[ADDR_W-1:0])
			read_value = irq_en_word;
		else
			mapped = 1'b0;
	end

	// write strobes land on the edge that completes the access
	assign clear_wr  = access & pwrite & (paddr == CLEAR_REG_OFS[ADDR_W-1:0]);
	assign irq_en_wr = access & pwrite & (paddr == IRQ_EN_REG_OFS[ADDR_W-1:0]);
	assign flag_wr   = access & pwrite & (paddr == FLAG_REG_OFS[ADDR_W-1:0]);

	// zero wait states: ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
		end
	end

	// read data register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= READ_ZERO;
		else if (setup & ~pwrite)
			prdata <= read_value;
	end

endmodule // apb_reg_port

`default_nettype wire

// ---- dma_channel_event_flags_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module dma_channel_event_flags_tb_top
	import dma_flags_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [6:0]  err_evt;
	logic [6:0]  half_evt;
	logic [6:0]  full_evt;
	logic [6:0]  channel_irq;
	logic [31:0] prdata_small;
	logic [4:0]  irq_small;
	logic [31:0] rd_small;
	logic [6:0]  race_ev;
	logic [31:0] rd_val;
	logic        rd_err;
	int          bad_count;
	int          checks;

	// 40 MHz clock
	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;

	dma_channel_event_flags dut
	(
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.err_evt     (err_evt),
		.half_evt    (half_evt),
		.full_evt    (full_evt),
		.channel_irq (channel_irq)
	);

	// five-channel instance on the same bus; its top channels must stay empty
	dma_channel_event_flags #(
		.NUM_CHANNELS (5)
	) dut_small (
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata_small),
		.pready      (),
		.pslverr     (),
		.err_evt     (err_evt[4:0]),
		.half_evt    (half_evt[4:0]),
		.full_evt    (full_evt[4:0]),
		.channel_irq (irq_small)
	);

	// verdict and end of run
	task finish_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one apb transfer; race_ev rides on err_evt in the access cycle only,
	// so it lands exactly on the edge where a write takes effect
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		err_evt <= race_ev;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd_val = prdata;
		rd_err = pslverr;
		rd_small = prdata_small;
		psel <= 1'b0;
		penable <= 1'b0;
		err_evt <= 7'h00;
		if (pready !== 1'b1)
		begin
			bad_count++;
			$display("CHECK FAILED pready expected 1 seen %b", pready);
			finish_test();
		end
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd_val);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// one-cycle event strobes; returns once the flags have landed
	task ev(input logic [6:0] e, input logic [6:0] h, input logic [6:0] f);
		@(posedge pclk);
		err_evt <= e;
		half_evt <= h;
		full_evt <= f;
		@(posedge pclk);
		err_evt <= 7'h00;
		half_evt <= 7'h00;
		full_evt <= 7'h00;
		#1;
	endtask

	task t_reset();
		rd(FLAG_REG_OFS, FLAG_RESET, "flags after reset");
		rd(IRQ_EN_REG_OFS, IRQ_EN_RESET, "enables after reset");
		rd(CLEAR_REG_OFS, READ_ZERO, "clear reg read");
		$display("test reset done");
	endtask

	// every kind of event on every channel, each dropped by the group clear
	task t_sets();
		logic [6:0]  m;
		logic [31:0] exp_word;
		for (int c = 0; c < 7; c++)
			for (int k = 1; k < 4; k++)
			begin
				m = 7'h01 << c;
				exp_word = (32'h1 << (4 * c + k)) | (32'h1 << (4 * c));
				ev(k == 3 ? m : 7'h00, k == 2 ? m : 7'h00, k == 1 ? m : 7'h00);
				rd(FLAG_REG_OFS, exp_word, "flag");
				chk("small flag", c < 5 ? exp_word : 32'h0, rd_small);
				wr(CLEAR_REG_OFS, 32'h1 << (4 * c));
				rd(FLAG_REG_OFS, 32'h0, "group clear");
				chk("small group clear", 32'h0, rd_small);
			end
		$display("test sets done");
	endtask

	task t_clear();
		ev(7'h04, 7'h04, 7'h00);
		wr(FLAG_REG_OFS, 32'h0FFFFFFF);
		chk("flag write error", 32'h0, {31'h0, rd_err});
		rd(FLAG_REG_OFS, 32'h00000D00, "after direct write");
		wr(CLEAR_REG_OFS, 32'h0);
		rd(FLAG_REG_OFS, 32'h00000D00, "zero clear");
		wr(CLEAR_REG_OFS, 32'h00000800);
		rd(FLAG_REG_OFS, 32'h00000500, "error clear");
		rd(12'h00C, 32'h0, "unmapped read");
		chk("unmapped error", 32'h1, {31'h0, rd_err});
		wr(CLEAR_REG_OFS, 32'h00000100);
		rd(FLAG_REG_OFS, 32'h0, "group clear");
		$display("test clear done");
	endtask

	task t_irq();
		wr(IRQ_EN_REG_OFS, 32'hFFFFFFFF);
		rd(IRQ_EN_REG_OFS, 32'h0EEEEEEE, "enable readback");
		chk("small enable readback", 32'h000EEEEE, rd_small);
		chk("irq idle", 32'h0, {25'h0, channel_irq});
		ev(7'h00, 7'h02, 7'h00);
		chk("irq half", 32'h2, {25'h0, channel_irq});
		chk("small irq half", 32'h2, {27'h0, irq_small});
		wr(IRQ_EN_REG_OFS, 32'h0);
		@(posedge pclk);
		#1;
		chk("irq masked", 32'h0, {25'h0, channel_irq});
		rd(FLAG_REG_OFS, 32'h00000050, "flag kept masked");
		wr(CLEAR_REG_OFS, 32'h00000010);
		$display("test irq done");
	endtask

	// event and clear on the same edge: the event must survive
	task t_race();
		race_ev = 7'h10;
		wr(CLEAR_REG_OFS, 32'h000F0000);
		race_ev = 7'h00;
		rd(FLAG_REG_OFS, 32'h00090000, "set beats clear");
		chk("small set beats clear", 32'h00090000, rd_small);
		wr(CLEAR_REG_OFS, 32'h00010000);
		rd(FLAG_REG_OFS, 32'h0, "race cleanup");
		$display("test race done");
	endtask

	// main sequence
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_evt = 7'h00;
		half_evt = 7'h00;
		full_evt = 7'h00;
		race_ev = 7'h00;
		bad_count = 0;
		checks = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_sets();
		t_clear();
		t_irq();
		t_race();
		finish_test();
	end
endmodule // dma_channel_event_flags_tb_top

`default_nettype wire
